/* verilog/buffer_steer.sv */
`timescale 1ns/10ps
`default_nettype none


module buffer_steer
  import steer_pkg::*;
(
  input wire logic clk,                 // bus clock, 100 MHz
  input wire logic rst_n,               // synchronous reset, active low
  input wire cycle_t cycle,             // cycle description from controller
  input wire logic eisa_master,         // EISA (not ISA) master owns the bus
  input wire logic addr_latch_req,      // close the address latch
  output swap_ctl_t swap_ctl,           // swap buffer control, registered
  output logic addr_latch_strobe_n,     // address latch strobe
  output logic upper_to_lower_addr_oe_n, // LA to SA enable
  output logic lower_to_upper_addr_oe_n  // SA to LA enable
);

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------

  // maps the four lane strobes onto the three output enables
  function automatic logic [2:0] lanes_to_oe(input logic [3:0] lanes);
    lanes_to_oe = {lanes[3] | lanes[2], lanes[1], lanes[0]};
  endfunction : lanes_to_oe

  wire logic mis_active;
  wire logic drive_ok;
  wire logic latch_ok;
  wire logic copy_up;
  wire logic [2:0] oe_nxt;
  wire logic [3:0] le_nxt;

  assign mis_active = cycle.active & cycle.mismatch;
  assign drive_ok = mis_active & cycle.drive_phase;
  assign latch_ok = mis_active & cycle.latch_phase & ~cycle.bridge_write;
  assign copy_up = cycle.master_width < cycle.slave_width;
  assign oe_nxt = drive_ok ? ~lanes_to_oe(cycle.lanes) : SWAP_OE_IDLE;
  assign le_nxt = latch_ok ? ~cycle.lanes : SWAP_LE_IDLE;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------

  swap_ctl_t ctl_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_r <= '{swap_out_enable_n: SWAP_OE_IDLE, swap_latch_enable_n: SWAP_LE_IDLE,
                 byte_copy_direction: 1'b0};
    end else begin
      ctl_r.swap_out_enable_n <= oe_nxt;
      ctl_r.swap_latch_enable_n <= le_nxt;
      if (mis_active) begin
        ctl_r.byte_copy_direction <= copy_up;
      end
    end
  end

  assign swap_ctl = ctl_r;

  addr_steer u_addr (
    .clk(clk),
    .rst_n(rst_n),
    .eisa_master(eisa_master),
    .addr_latch_req(addr_latch_req),
    .addr_latch_strobe_n(addr_latch_strobe_n),
    .upper_to_lower_addr_oe_n(upper_to_lower_addr_oe_n),
    .lower_to_upper_addr_oe_n(lower_to_upper_addr_oe_n)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------

  AST_OE_ONLY_MIS: assert property (@(posedge clk) disable iff (!rst_n)
    !(cycle.active && cycle.mismatch) |=> swap_ctl.swap_out_enable_n == 3'h7)
    else $error("swap output enable outside mismatched cycle");
  AST_OE_UPPER: assert property (@(posedge clk) disable iff (!rst_n)
    drive_ok && cycle.lanes[3] |=> !swap_ctl.swap_out_enable_n[2])
    else $error("upper lanes not enabled");
  AST_LE_BRIDGE_WR: assert property (@(posedge clk) disable iff (!rst_n)
    cycle.bridge_write |=> swap_ctl.swap_latch_enable_n == 4'hF)
    else $error("latch enable during bridge write");
  AST_LE_LANE: assert property (@(posedge clk) disable iff (!rst_n)
    latch_ok |=> swap_ctl.swap_latch_enable_n == ~$past(cycle.lanes))
    else $error("latch enable lane mismatch");
  AST_COPY_DIR: assert property (@(posedge clk) disable iff (!rst_n)
    mis_active |=> swap_ctl.byte_copy_direction == $past(copy_up))
    else $error("copy direction wrong");
  AST_RESET_IDLE: assert property (@(posedge clk)
    !rst_n |=> swap_ctl.swap_out_enable_n == 3'h7 && swap_ctl.swap_latch_enable_n == 4'hF
      && upper_to_lower_addr_oe_n && lower_to_upper_addr_oe_n)
    else $error("enables active after reset edge");

  // ------------------------------------------------------------
  // checks: swap buffer steering per lane
  // ------------------------------------------------------------

  // each low lane owns its enable; a stuck bit here garbles only one byte
  AST_OE_LANE0: assert property (@(posedge clk) disable iff (!rst_n)
    drive_ok |=> swap_ctl.swap_out_enable_n[0] == !$past(cycle.lanes[0]))
    else $error("lane 0 output enable wrong");

  AST_OE_LANE1: assert property (@(posedge clk) disable iff (!rst_n)
    drive_ok |=> swap_ctl.swap_out_enable_n[1] == !$past(cycle.lanes[1]))
    else $error("lane 1 output enable wrong");

  // the shared upper enable must stay off when neither upper lane moves
  AST_OE_UPPER_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    drive_ok && !cycle.lanes[3] && !cycle.lanes[2] |=> swap_ctl.swap_out_enable_n[2])
    else $error("upper lanes enabled without request");

  AST_OE_PHASE: assert property (@(posedge clk) disable iff (!rst_n)
    !cycle.drive_phase |=> swap_ctl.swap_out_enable_n == SWAP_OE_IDLE)
    else $error("swap output enable outside drive phase");

  AST_OE_NO_LANES: assert property (@(posedge clk) disable iff (!rst_n)
    drive_ok && cycle.lanes == 4'h0 |=> swap_ctl.swap_out_enable_n == SWAP_OE_IDLE)
    else $error("swap output enable with no lane");

  // a latch opening outside a mismatch would overwrite assembled data
  AST_LE_ONLY_MIS: assert property (@(posedge clk) disable iff (!rst_n)
    !mis_active |=> swap_ctl.swap_latch_enable_n == SWAP_LE_IDLE)
    else $error("latch enable outside mismatched cycle");

  AST_LE_PHASE: assert property (@(posedge clk) disable iff (!rst_n)
    !cycle.latch_phase |=> swap_ctl.swap_latch_enable_n == SWAP_LE_IDLE)
    else $error("latch enable outside latch phase");

  AST_LE_LANE0: assert property (@(posedge clk) disable iff (!rst_n)
    latch_ok |=> swap_ctl.swap_latch_enable_n[0] == !$past(cycle.lanes[0]))
    else $error("lane 0 latch enable wrong");

  AST_LE_LANE1: assert property (@(posedge clk) disable iff (!rst_n)
    latch_ok |=> swap_ctl.swap_latch_enable_n[1] == !$past(cycle.lanes[1]))
    else $error("lane 1 latch enable wrong");

  AST_LE_LANE2: assert property (@(posedge clk) disable iff (!rst_n)
    latch_ok |=> swap_ctl.swap_latch_enable_n[2] == !$past(cycle.lanes[2]))
    else $error("lane 2 latch enable wrong");

  AST_LE_LANE3: assert property (@(posedge clk) disable iff (!rst_n)
    latch_ok |=> swap_ctl.swap_latch_enable_n[3] == !$past(cycle.lanes[3]))
    else $error("lane 3 latch enable wrong");

  AST_LE_NO_LANES: assert property (@(posedge clk) disable iff (!rst_n)
    latch_ok && cycle.lanes == 4'h0 |=> swap_ctl.swap_latch_enable_n == SWAP_LE_IDLE)
    else $error("latch enable with no lane");

  // direction is judged from the widths alone, not from the phase
  AST_COPY_UP: assert property (@(posedge clk) disable iff (!rst_n)
    mis_active && cycle.master_width < cycle.slave_width |=> swap_ctl.byte_copy_direction)
    else $error("copy up not requested");

  AST_COPY_DOWN: assert property (@(posedge clk) disable iff (!rst_n)
    mis_active && cycle.master_width >= cycle.slave_width |=> !swap_ctl.byte_copy_direction)
    else $error("copy down not requested");

  // holding avoids a direction glitch between two steps of one cycle
  AST_COPY_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !mis_active |=> $stable(swap_ctl.byte_copy_direction))
    else $error("copy direction moved outside mismatch");

  // ------------------------------------------------------------
  // checks: address transceiver steering
  // ------------------------------------------------------------

  // the first cycle after release still shows both enables off
  AST_ADDR_COMPL: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> upper_to_lower_addr_oe_n != lower_to_upper_addr_oe_n)
    else $error("address enables not complementary");

  AST_ADDR_ONE_ON: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> !(upper_to_lower_addr_oe_n && lower_to_upper_addr_oe_n))
    else $error("no address direction enabled");

  AST_ADDR_ISA_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && !eisa_master |=> upper_to_lower_addr_oe_n)
    else $error("LA to SA enabled for ISA master");

  AST_ADDR_EISA_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && eisa_master |=> lower_to_upper_addr_oe_n)
    else $error("SA to LA enabled for EISA master");

  AST_STROBE_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    addr_latch_req |=> !addr_latch_strobe_n)
    else $error("address latch strobe not low after request");

  // an early rise would latch a half-settled address
  AST_STROBE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    !addr_latch_req |=> addr_latch_strobe_n)
    else $error("address latch strobe low without request");

  AST_RESET_ADDR: assert property (@(posedge clk)
    !rst_n |=> addr_latch_strobe_n)
    else $error("address latch strobe active after reset edge");

endmodule : buffer_steer

`default_nettype wire

/* verilog/steer_pkg.sv */
package steer_pkg;

  // number of swap output enables and swap latch enables
  localparam int SWAP_OE_W = 3;
  localparam int SWAP_LE_W = 4;

  // inactive levels applied during reset (all active low)
  localparam logic [2:0] SWAP_OE_IDLE = 3'h7;
  localparam logic [3:0] SWAP_LE_IDLE = 4'hF;

  // width code of a transfer: 8, 16 or 32 bits
  typedef enum logic [1:0] {
    WIDTH_8  = 2'h0,
    WIDTH_16 = 2'h1,
    WIDTH_32 = 2'h2
  } width_t;

  // description of the cycle in progress, from the bus controller
  typedef struct packed {
    logic active;           // a bus cycle is in progress
    logic mismatch;         // master and slave widths differ
    logic bridge_write;     // write cycle started by the bridge
    width_t master_width;   // width of the initiating master
    width_t slave_width;    // width of the responding slave
    logic [3:0] lanes;      // byte lanes being moved this step
    logic latch_phase;      // data valid, latch now
    logic drive_phase;      // drive assembled data now
  } cycle_t;

  // buffer steering outputs
  typedef struct packed {
    logic [2:0] swap_out_enable_n;
    logic [3:0] swap_latch_enable_n;
    logic byte_copy_direction;
  } swap_ctl_t;

endpackage : steer_pkg

/* verilog/addr_steer.sv */
`timescale 1ns/10ps
`default_nettype none

// address transceiver steering between the latched and system address buses
module addr_steer
  import steer_pkg::*;
(
  input wire logic clk,                 // bus clock
  input wire logic rst_n,               // synchronous reset, active low
  input wire logic eisa_master,         // an EISA master owns the bus
  input wire logic addr_latch_req,      // close the address latch; strobe goes low next cycle
  output logic addr_latch_strobe_n,     // rising edge latches LA[19:2]
  output logic upper_to_lower_addr_oe_n, // LA to SA direction enable
  output logic lower_to_upper_addr_oe_n  // SA to LA direction enable
);

  logic strobe_r;
  logic dir_r;
  logic oe_valid_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strobe_r <= 1'b1;
      dir_r <= 1'b1;
      oe_valid_r <= 1'b0;
    end else begin
      strobe_r <= ~addr_latch_req;
      dir_r <= eisa_master;
      oe_valid_r <= 1'b1;
    end
  end

  assign addr_latch_strobe_n = strobe_r;
  assign upper_to_lower_addr_oe_n = ~(oe_valid_r & dir_r);
  // exact complement from the first clock edge after reset release
  assign lower_to_upper_addr_oe_n = ~(oe_valid_r & ~dir_r);

  AST_ADDR_EXCL: assert property (@(posedge clk) disable iff (!rst_n)
    !(!upper_to_lower_addr_oe_n && !lower_to_upper_addr_oe_n))
    else $error("both address directions enabled");
  AST_ADDR_DIR: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && eisa_master |=> !upper_to_lower_addr_oe_n)
    else $error("LA to SA enable missing for EISA master");
  AST_ADDR_ISA: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && !eisa_master |=> !lower_to_upper_addr_oe_n)
    else $error("SA to LA enable missing for ISA master");
  AST_STROBE: assert property (@(posedge clk) disable iff (!rst_n)
    addr_latch_req ##1 !addr_latch_req |-> !addr_latch_strobe_n ##1 addr_latch_strobe_n)
    else $error("address latch strobe edge misplaced");

endmodule : addr_steer

`default_nettype wire

/* sim/swap_bridge_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------
// bridge side swap buffers
// ---------------------------------
module swap_bridge_model
  import steer_pkg::*;
(
  input wire logic clk, // bus clock
  input wire swap_ctl_t ctl, // steering from the block
  input wire logic [31:0] sd, // data on the bus
  output logic [31:0] held, // latched lanes
  output logic [31:0] sd_drv // lanes driven back
);
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!ctl.swap_latch_enable_n[i]) begin
        held[8*i +: 8] <= sd[8*i +: 8];
      end
    end
  end
  // enable 2 opens both upper lanes; a released lane shows the inverse so stale data never matches
  assign sd_drv[7:0] = ctl.swap_out_enable_n[0] ? ~held[7:0] : held[7:0];
  assign sd_drv[15:8] = ctl.swap_out_enable_n[1] ? ~held[15:8] : held[15:8];
  assign sd_drv[31:16] = ctl.swap_out_enable_n[2] ? ~held[31:16] : held[31:16];
endmodule : swap_bridge_model
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; $display("wrong value at %0t: output differs", $time); end end
// ---------------------------------
// bench
// ---------------------------------
module testbench;
  import steer_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cycle_t cycle = '0;
  logic eisa_master = 1'b0;
  logic addr_latch_req = 1'b0;
  logic [31:0] sd = 32'hA1B2C3D4;
  logic [31:0] held;
  logic [31:0] sd_drv;
  swap_ctl_t swap_ctl;
  logic strobe_n;
  logic u2l_n;
  logic l2u_n;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [3:0] ln [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hC, 4'hF};
  logic [2:0] oe [6] = '{3'h6, 3'h5, 3'h3, 3'h3, 3'h3, 3'h0};
  buffer_steer u_buffer_steer (.clk(clk), .rst_n(rst_n), .cycle(cycle), .eisa_master(eisa_master),
    .addr_latch_req(addr_latch_req), .swap_ctl(swap_ctl), .addr_latch_strobe_n(strobe_n),
    .upper_to_lower_addr_oe_n(u2l_n), .lower_to_upper_addr_oe_n(l2u_n));
  swap_bridge_model u_swap_bridge_model (.clk(clk), .ctl(swap_ctl), .sd(sd), .held(held), .sd_drv(sd_drv));
  initial begin
    forever #5 clk = ~clk;
  end
  // a hang ends the run after far more cycles than the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      test_done();
    end
  end
  task test_done;
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task apply(input cycle_t c, input logic em, input logic req);
    @(posedge clk);
    cycle <= c;
    eisa_master <= em;
    addr_latch_req <= req;
    @(posedge clk);
    #1;
  endtask : apply
  task t_latch;
    for (int i = 0; i < 4; i++) begin
      apply(cycle_t'{1'b1, 1'b1, 1'b0, WIDTH_8, WIDTH_32, 4'h1 << i, 1'b1, 1'b0}, 1'b0, 1'b0);
      `CHK(swap_ctl.swap_latch_enable_n, ~(4'h1 << i))
    end
    apply(cycle_t'{1'b1, 1'b1, 1'b1, WIDTH_8, WIDTH_32, 4'hF, 1'b1, 1'b0}, 1'b0, 1'b0);
    `CHK(swap_ctl.swap_latch_enable_n, SWAP_LE_IDLE)
    `CHK(held, sd)
    apply(cycle_t'{1'b1, 1'b0, 1'b0, WIDTH_8, WIDTH_8, 4'hF, 1'b1, 1'b1}, 1'b0, 1'b0);
    `CHK(swap_ctl.swap_latch_enable_n, SWAP_LE_IDLE)
    `CHK(swap_ctl.swap_out_enable_n, SWAP_OE_IDLE)
  endtask : t_latch
  task t_drive;
    for (int i = 0; i < 6; i++) begin
      apply(cycle_t'{1'b1, 1'b1, 1'b0, WIDTH_8, WIDTH_32, ln[i], 1'b0, 1'b1}, 1'b0, 1'b0);
      `CHK(swap_ctl.swap_out_enable_n, oe[i])
      if (i == 4) `CHK({sd_drv[31:16], ~sd_drv[7:0]}, {sd[31:16], sd[7:0]})
    end
  endtask : t_drive
  task t_addr;
    apply('0, 1'b1, 1'b1);
    `CHK({strobe_n, u2l_n, l2u_n}, 3'h1)
    apply('0, 1'b0, 1'b0);
    `CHK({strobe_n, u2l_n, l2u_n}, 3'h6)
  endtask : t_addr
  task t_copy;
    apply(cycle_t'{1'b1, 1'b1, 1'b0, WIDTH_8, WIDTH_32, 4'h1, 1'b0, 1'b0}, 1'b1, 1'b0);
    `CHK({swap_ctl.byte_copy_direction, u2l_n, l2u_n}, 3'h5)
    apply(cycle_t'{1'b1, 1'b1, 1'b0, WIDTH_32, WIDTH_16, 4'h1, 1'b0, 1'b0}, 1'b1, 1'b0);
    `CHK({swap_ctl.byte_copy_direction, u2l_n, l2u_n}, 3'h1)
    apply(cycle_t'{1'b0, 1'b0, 1'b0, WIDTH_8, WIDTH_32, 4'h1, 1'b0, 1'b0}, 1'b0, 1'b0);
    `CHK(swap_ctl.byte_copy_direction, 1'b0)
  endtask : t_copy
  initial begin
    repeat (20) @(posedge clk);
    #1;
    `CHK({swap_ctl.swap_out_enable_n, swap_ctl.swap_latch_enable_n}, {SWAP_OE_IDLE, SWAP_LE_IDLE})
    `CHK({strobe_n, u2l_n, l2u_n}, 3'h7)
    @(posedge clk);
    rst_n <= 1'b1;
    t_latch();
    t_drive();
    t_addr();
    t_copy();
    test_done();
  end
endmodule : testbench
`default_nettype wire
